// >>> crs_alu.sv
/*
  arithmetic unit for the register set: unary byte ops, multiply, divide.
  assumes purely combinational use from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_alu
(
  input wire logic [7:0] i_operand,
  input wire crs_pkg::crs_fn_type i_fn,
  input wire logic i_carry,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_x,
  input wire logic [7:0] i_h,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_overflow,
  output logic [15:0] o_product,
  output logic [7:0] o_quotient,
  output logic [7:0] o_remainder,
  output logic o_div_error
);

  logic [15:0] dividend;
  logic [15:0] quot_full;
  logic [15:0] rem_full;

  // ==========================================================
  // unary byte operations
  always_comb
  begin
    o_result = i_operand;
    o_carry = i_carry;
    o_overflow = 1'b0;
    case (i_fn)
      crs_pkg::FN_CLR:
      begin
        o_result = crs_pkg::ZERO8;
      end
      crs_pkg::FN_INC:
      begin
        o_result = i_operand + 8'h01;
        o_overflow = (i_operand == 8'h7f);
      end
      crs_pkg::FN_DEC:
      begin
        o_result = i_operand - 8'h01;
        o_overflow = (i_operand == 8'h80);
      end
      crs_pkg::FN_COM:
      begin
        o_result = ~i_operand;
        o_carry = 1'b1;
      end
      crs_pkg::FN_NEG:
      begin
        o_result = crs_pkg::ZERO8 - i_operand;
        o_carry = (i_operand != crs_pkg::ZERO8);
        o_overflow = (i_operand == 8'h80);
      end
      crs_pkg::FN_LSL:
      begin
        o_result = {i_operand[6:0], 1'b0};
        o_carry = i_operand[7];
      end
      crs_pkg::FN_LSR:
      begin
        o_result = {1'b0, i_operand[7:1]};
        o_carry = i_operand[0];
      end
      crs_pkg::FN_ASR:
      begin
        o_result = {i_operand[7], i_operand[7:1]};
        o_carry = i_operand[0];
      end
      crs_pkg::FN_ROL:
      begin
        o_result = {i_operand[6:0], i_carry};
        o_carry = i_operand[7];
      end
      crs_pkg::FN_ROR:
      begin
        o_result = {i_carry, i_operand[7:1]};
        o_carry = i_operand[0];
      end
      default:
      begin
        o_result = i_operand;
      end
    endcase
  end

  // ==========================================================
  // multiply and divide
  assign o_product = i_x * i_acc;
  assign dividend = {i_h, i_acc};
  assign quot_full = (i_x == crs_pkg::ZERO8) ? 16'h0000 : dividend / {8'h00, i_x};
  assign rem_full = (i_x == crs_pkg::ZERO8) ? 16'h0000 : dividend % {8'h00, i_x};
  assign o_quotient = quot_full[7:0];
  assign o_remainder = rem_full[7:0];
  assign o_div_error = (i_x == crs_pkg::ZERO8) || (quot_full[15:8] != crs_pkg::ZERO8);

endmodule

`default_nettype wire

// >>> crs_mem_model.sv
/*
  behavioural model of the unified 64-kbyte memory on the far side.
  assumes one read pulse per byte and answers one clock later.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_mem_model
(
  input wire logic i_clock,
  input wire crs_pkg::crs_mem_type i_mem,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];

  initial o_rdata = 8'h5a;

  // ==========================================================
  // storage and read port
  // flat byte space, memory only
  always @(posedge i_clock)
  begin
    if (i_mem.wr)
      mem[i_mem.addr] <= i_mem.wdata;
    if (i_mem.rd)
      o_rdata <= mem[i_mem.addr];
    else
      o_rdata <= ~o_rdata;
  end
endmodule

`default_nettype wire

// >>> crs_monitor.sv
/*
  checker for the register set ports.
  assumes a bind to crs_register_set and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module crs_monitor
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire crs_pkg::crs_cmd_type i_cmd,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_busy,
  input wire crs_pkg::crs_mem_type o_mem,
  input wire logic [15:0] o_direct_addr,
  input wire crs_pkg::crs_regs_type o_regs
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // ==========================================================
  // helpers
  logic tk;
  logic [15:0] sx;
  assign tk = i_cmd_valid && !o_busy;
  assign sx = {{8{i_cmd.data[7]}}, i_cmd.data};

  // ==========================================================
  // assertions
  chk_reset_vals:
    assert property ($rose(i_reset_n) |-> o_regs.stack_pointer == 16'h00ff &&
      o_regs.index_pair[15:8] == 8'h00 && o_mem.rd && o_mem.addr == 16'hfffe)
      else $error("reset values wrong");
  chk_fixed_flags:
    assert property (o_regs.condition_flags[6:5] == 2'b11)
      else $error("fixed flag bits low");
  chk_fetch_step:
    assert property (tk && i_cmd.op == crs_pkg::OP_FETCH |-> o_mem.rd &&
      o_mem.addr == o_regs.program_counter ##1
      o_regs.program_counter == $past(o_regs.program_counter) + 16'h0001)
      else $error("fetch did not advance");
  chk_branch_add:
    assert property (tk && i_cmd.op == crs_pkg::OP_BRANCH |=> o_regs.program_counter ==
      $past(o_regs.program_counter) + ($past(i_cmd.taken) ? $past(sx) : 16'h0000))
      else $error("branch target wrong");
  chk_stack_add:
    assert property (tk && i_cmd.op == crs_pkg::OP_ADD_IMMEDIATE_TO_STACK |=>
      o_regs.stack_pointer == $past(o_regs.stack_pointer) + $past(sx))
      else $error("stack add wrong");
  chk_stack_low:
    assert property (tk && i_cmd.op == crs_pkg::OP_STACK_LOW_BYTE_RESET |=>
      o_regs.stack_pointer == {$past(o_regs.stack_pointer[15:8]), 8'hff})
      else $error("stack low reset wrong");
  chk_direct_page:
    assert property (o_direct_addr == {8'h00, i_cmd.data})
      else $error("direct address off page");
  chk_call_push:
    assert property (tk && i_cmd.op == crs_pkg::OP_CALL |=> o_mem.wr &&
      o_mem.addr == $past(o_regs.stack_pointer) &&
      o_mem.wdata == $past(o_regs.program_counter[7:0]) ##1 o_mem.wr &&
      o_mem.wdata == $past(o_regs.program_counter[15:8], 2) ##1 !o_busy &&
      o_regs.program_counter == $past(i_cmd.target, 3))
      else $error("call push wrong");
  chk_int_mask:
    assert property (tk && i_cmd.op == crs_pkg::OP_INTERRUPT |=> o_mem.wr [*5] ##[1:8]
      !o_busy && o_regs.condition_flags[3])
      else $error("interrupt mask not set");
  chk_idle_hold:
    assert property (!o_busy && !i_cmd_valid |=> $stable(o_regs))
      else $error("register changed while idle");

  cov_call: cover property (tk && i_cmd.op == crs_pkg::OP_CALL);
  cov_int: cover property (tk && i_cmd.op == crs_pkg::OP_INTERRUPT);
  cov_move: cover property (tk && i_cmd.op == crs_pkg::OP_MOVE);
endmodule

bind crs_register_set crs_monitor MON (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy),
  .o_mem(o_mem), .o_direct_addr(o_direct_addr), .o_regs(o_regs));

`default_nettype wire

// >>> crs_pkg.sv
/*
  package for the cpu register set: constants, command and state types.
  assumes one clock domain and a unified 64-kbyte memory space outside.
*/
`default_nettype none

package crs_pkg;

  // ==========================================================
  // reset values and fixed addresses
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] H_RESET = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] RSP_LOW = 8'hff;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] ZERO8 = 8'h00;

  // ==========================================================
  // condition flag layout
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // ==========================================================
  // stack frame byte indexes, pushed from 0 upward
  localparam logic [2:0] IDX_PCL = 3'h0;
  localparam logic [2:0] IDX_PCH = 3'h1;
  localparam logic [2:0] IDX_X = 3'h2;
  localparam logic [2:0] IDX_A = 3'h3;
  localparam logic [2:0] IDX_CCR = 3'h4;
  localparam logic [2:0] CALL_LAST = 3'h1;
  localparam logic [2:0] INT_LAST = 3'h4;
  localparam logic [2:0] VEC_LAST = 3'h1;

  // ==========================================================
  // types
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_FETCH = 5'h01,
    OP_JUMP = 5'h02,
    OP_BRANCH = 5'h03,
    OP_LOAD_A = 5'h04,
    OP_LOAD_X = 5'h05,
    OP_LOAD_H = 5'h06,
    OP_LOAD_HX = 5'h07,
    OP_ALU_A = 5'h08,
    OP_ALU_X = 5'h09,
    OP_MUL = 5'h0a,
    OP_DIV = 5'h0b,
    OP_ADD_IMMEDIATE_TO_STACK = 5'h0c,
    OP_STACK_LOW_BYTE_RESET = 5'h0d,
    OP_LOAD_SP = 5'h0e,
    OP_HX_POST_INC = 5'h0f,
    OP_CALL = 5'h10,
    OP_RETURN = 5'h11,
    OP_INTERRUPT = 5'h12,
    OP_RETURN_INT = 5'h13,
    OP_MOVE = 5'h14,
    OP_LOAD_FLAGS = 5'h15
  } crs_op_type;

  typedef enum logic [3:0] {
    FN_CLR = 4'h0,
    FN_INC = 4'h1,
    FN_DEC = 4'h2,
    FN_COM = 4'h3,
    FN_NEG = 4'h4,
    FN_LSL = 4'h5,
    FN_LSR = 4'h6,
    FN_ASR = 4'h7,
    FN_ROL = 4'h8,
    FN_ROR = 4'h9
  } crs_fn_type;

  typedef enum logic [3:0] {
    ST_VEC_A = 4'h0,
    ST_VEC_D = 4'h1,
    ST_IDLE = 4'h2,
    ST_PUSH = 4'h3,
    ST_PULL_A = 4'h4,
    ST_PULL_D = 4'h5,
    ST_MOVE_RD = 4'h6,
    ST_MOVE_WR = 4'h7
  } crs_state_type;

  typedef struct packed {
    crs_op_type op;
    crs_fn_type fn;
    logic [7:0] data;
    logic [15:0] target;
    logic taken;
  } crs_cmd_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] index_pair;
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [7:0] condition_flags;
  } crs_regs_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crs_mem_type;

endpackage

`default_nettype wire

// >>> crs_register_set.sv
/*
  programmer register set: accumulator, index pair, stack pointer,
  program counter and condition flags, with stack and vector sequencing.
  assumes a decoder issues commands when o_busy is low and a memory that
  returns read data one clock after o_mem.rd.
*/
// Function
// - 8-bit accumulator, alu operand, reset keeps
// - index pair from high and low bytes
// - indexed uses full pair; some ops low
// - reset clears high index, keeps low
// - low index byte supports unary ops
// - stack pointer addresses next free location
// - reset loads stack pointer with 00ff
// - add signed immediate to stack pointer
// - stack reset changes low byte only
// - program counter increments on each fetch
// - jump branch interrupt return load target
// - reset loads pc from top vector
// - calls push pc; interrupts push registers
// - one flat 64-kbyte address space
// - direct mode reaches lowest page only
// - registers not in memory map
// - 8x8 multiply and 16/8 divide
// - relative uses signed 8-bit displacement
// - five index submodes, one auto-increment
// - memory to memory moves
// - flag bits 6 and 5 fixed one
// - interrupt mask set after stacking
// - taken branch adds sign-extended displacement
`timescale 1ns/10ps
`default_nettype none

module crs_register_set
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire crs_pkg::crs_cmd_type i_cmd,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy,
  output crs_pkg::crs_mem_type o_mem,
  output logic [15:0] o_direct_addr,
  output crs_pkg::crs_regs_type o_regs
);

  crs_pkg::crs_state_type state_q;
  logic [2:0] cnt_q;
  logic [2:0] last_q;
  logic is_int_q;
  logic [15:0] target_q;
  logic [15:0] vec_base_q;
  logic [15:0] move_src_q;
  logic [7:0] move_dst_q;
  logic [7:0] acc_q;
  logic [7:0] h_q;
  logic [7:0] x_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic take;
  crs_pkg::crs_op_type op;
  logic [7:0] alu_in;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_v;
  logic [15:0] product;
  logic [7:0] quotient;
  logic [7:0] remainder;
  logic div_err;
  logic [15:0] hx_inc;
  logic push_done;

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[crs_pkg::FLAG_N] = r[7];
    o[crs_pkg::FLAG_Z] = (r == crs_pkg::ZERO8);
    return o;
  endfunction

  assign take = i_cmd_valid && (state_q == crs_pkg::ST_IDLE);
  assign op = i_cmd.op;
  assign hx_inc = {h_q, x_q} + crs_pkg::ONE16;
  assign push_done = (state_q == crs_pkg::ST_PUSH) && (cnt_q == last_q);
  assign alu_in = (op == crs_pkg::OP_ALU_X) ? x_q : acc_q;

  // ==========================================================
  // arithmetic unit
  // multiply divide unit
  crs_alu u_alu
  (
    .i_operand(alu_in),
    .i_fn(i_cmd.fn),
    .i_carry(flags_q[crs_pkg::FLAG_C]),
    .i_acc(acc_q),
    .i_x(x_q),
    .i_h(h_q),
    .o_result(alu_res),
    .o_carry(alu_c),
    .o_overflow(alu_v),
    .o_product(product),
    .o_quotient(quotient),
    .o_remainder(remainder),
    .o_div_error(div_err)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= crs_pkg::ST_VEC_A;
      cnt_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        crs_pkg::ST_IDLE:
        begin
          if (take && (op == crs_pkg::OP_CALL || op == crs_pkg::OP_INTERRUPT))
          begin
            state_q <= crs_pkg::ST_PUSH;
            cnt_q <= 3'h0;
          end
          else if (take && op == crs_pkg::OP_RETURN)
          begin
            state_q <= crs_pkg::ST_PULL_A;
            cnt_q <= crs_pkg::CALL_LAST;
          end
          else if (take && op == crs_pkg::OP_RETURN_INT)
          begin
            state_q <= crs_pkg::ST_PULL_A;
            cnt_q <= crs_pkg::INT_LAST;
          end
          else if (take && op == crs_pkg::OP_MOVE)
          begin
            state_q <= crs_pkg::ST_MOVE_RD;
          end
        end
        crs_pkg::ST_PUSH:
        begin
          if (cnt_q != last_q)
          begin
            cnt_q <= cnt_q + 3'h1;
          end
          else if (is_int_q)
          begin
            state_q <= crs_pkg::ST_VEC_A;
            cnt_q <= 3'h0;
          end
          else
          begin
            state_q <= crs_pkg::ST_IDLE;
          end
        end
        crs_pkg::ST_PULL_A:
        begin
          state_q <= crs_pkg::ST_PULL_D;
        end
        crs_pkg::ST_PULL_D:
        begin
          if (cnt_q == 3'h0)
          begin
            state_q <= crs_pkg::ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 3'h1;
            state_q <= crs_pkg::ST_PULL_A;
          end
        end
        crs_pkg::ST_VEC_A:
        begin
          state_q <= crs_pkg::ST_VEC_D;
        end
        crs_pkg::ST_VEC_D:
        begin
          if (cnt_q == crs_pkg::VEC_LAST)
          begin
            state_q <= crs_pkg::ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q + 3'h1;
            state_q <= crs_pkg::ST_VEC_A;
          end
        end
        crs_pkg::ST_MOVE_RD:
        begin
          state_q <= crs_pkg::ST_MOVE_WR;
        end
        default:
        begin
          state_q <= crs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // latched command operands
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      last_q <= 3'h0;
      is_int_q <= 1'b0;
      target_q <= crs_pkg::PC_RESET;
      vec_base_q <= crs_pkg::RESET_VECTOR;
      move_src_q <= crs_pkg::PC_RESET;
      move_dst_q <= crs_pkg::ZERO8;
    end
    else if (take)
    begin
      last_q <= (op == crs_pkg::OP_INTERRUPT) ? crs_pkg::INT_LAST : crs_pkg::CALL_LAST;
      is_int_q <= (op == crs_pkg::OP_INTERRUPT);
      target_q <= i_cmd.target;
      move_src_q <= i_cmd.target;
      move_dst_q <= i_cmd.data;
      if (op == crs_pkg::OP_INTERRUPT)
      begin
        vec_base_q <= i_cmd.target;
      end
    end
  end

  // ==========================================================
  // memory port
  always_comb
  begin
    o_mem = '0;
    case (state_q)
      crs_pkg::ST_IDLE:
      begin
        o_mem.rd = take && (op == crs_pkg::OP_FETCH);
        o_mem.addr = pc_q;
      end
      crs_pkg::ST_VEC_A:
      begin
        o_mem.rd = 1'b1;
        o_mem.addr = vec_base_q | {13'h0000, cnt_q};
      end
      crs_pkg::ST_PUSH:
      begin
        o_mem.wr = 1'b1;
        o_mem.addr = sp_q;
        if (cnt_q == crs_pkg::IDX_PCL)
          o_mem.wdata = pc_q[7:0];
        else if (cnt_q == crs_pkg::IDX_PCH)
          o_mem.wdata = pc_q[15:8];
        else if (cnt_q == crs_pkg::IDX_X)
          o_mem.wdata = x_q;
        else if (cnt_q == crs_pkg::IDX_A)
          o_mem.wdata = acc_q;
        else
          o_mem.wdata = flags_q;
      end
      crs_pkg::ST_PULL_A:
      begin
        o_mem.rd = 1'b1;
        o_mem.addr = sp_q + crs_pkg::ONE16;
      end
      crs_pkg::ST_MOVE_RD:
      begin
        o_mem.rd = 1'b1;
        o_mem.addr = move_src_q;
      end
      crs_pkg::ST_MOVE_WR:
      begin
        o_mem.wr = 1'b1;
        o_mem.addr = {crs_pkg::DIRECT_PAGE, move_dst_q};
        o_mem.wdata = i_mem_rdata;
      end
      default:
      begin
        o_mem = '0;
      end
    endcase
  end

  assign o_direct_addr = {crs_pkg::DIRECT_PAGE, i_cmd.data};

  // ==========================================================
  // program counter
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pc_q <= crs_pkg::PC_RESET;
    else if (state_q == crs_pkg::ST_VEC_D && cnt_q == 3'h0)
      pc_q <= {i_mem_rdata, pc_q[7:0]};
    else if (state_q == crs_pkg::ST_VEC_D)
      pc_q <= {pc_q[15:8], i_mem_rdata};
    else if (push_done && !is_int_q)
      pc_q <= target_q;
    else if (state_q == crs_pkg::ST_PULL_D && cnt_q == crs_pkg::IDX_PCH)
      pc_q <= {i_mem_rdata, pc_q[7:0]};
    else if (state_q == crs_pkg::ST_PULL_D && cnt_q == crs_pkg::IDX_PCL)
      pc_q <= {pc_q[15:8], i_mem_rdata};
    else if (take && op == crs_pkg::OP_FETCH)
      pc_q <= pc_q + crs_pkg::ONE16;
    else if (take && op == crs_pkg::OP_JUMP)
      pc_q <= i_cmd.target;
    else if (take && op == crs_pkg::OP_BRANCH && i_cmd.taken)
      pc_q <= pc_q + sext8(i_cmd.data);
  end

  // ==========================================================
  // stack pointer
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sp_q <= crs_pkg::SP_RESET;
    else if (state_q == crs_pkg::ST_PUSH)
      sp_q <= sp_q - crs_pkg::ONE16;
    else if (state_q == crs_pkg::ST_PULL_A)
      sp_q <= sp_q + crs_pkg::ONE16;
    else if (take && op == crs_pkg::OP_ADD_IMMEDIATE_TO_STACK)
      sp_q <= sp_q + sext8(i_cmd.data);
    else if (take && op == crs_pkg::OP_STACK_LOW_BYTE_RESET)
      sp_q <= {sp_q[15:8], crs_pkg::RSP_LOW};
    else if (take && op == crs_pkg::OP_LOAD_SP)
      sp_q <= i_cmd.target;
  end

  // ==========================================================
  // index pair high byte
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      h_q <= crs_pkg::H_RESET;
    else if (take && op == crs_pkg::OP_LOAD_H)
      h_q <= i_cmd.data;
    else if (take && op == crs_pkg::OP_LOAD_HX)
      h_q <= i_cmd.target[15:8];
    else if (take && op == crs_pkg::OP_HX_POST_INC)
      h_q <= hx_inc[15:8];
    else if (take && op == crs_pkg::OP_DIV && !div_err)
      h_q <= remainder;
  end

  // ==========================================================
  // index pair low byte, kept over reset
  always_ff @(posedge i_clock)
  begin
    if (state_q == crs_pkg::ST_PULL_D && cnt_q == crs_pkg::IDX_X)
      x_q <= i_mem_rdata;
    else if (take && op == crs_pkg::OP_LOAD_X)
      x_q <= i_cmd.data;
    else if (take && op == crs_pkg::OP_LOAD_HX)
      x_q <= i_cmd.target[7:0];
    else if (take && op == crs_pkg::OP_HX_POST_INC)
      x_q <= hx_inc[7:0];
    else if (take && op == crs_pkg::OP_ALU_X)
      x_q <= alu_res;
    else if (take && op == crs_pkg::OP_MUL)
      x_q <= product[15:8];
  end

  // ==========================================================
  // accumulator, kept over reset
  always_ff @(posedge i_clock)
  begin
    if (state_q == crs_pkg::ST_PULL_D && cnt_q == crs_pkg::IDX_A)
      acc_q <= i_mem_rdata;
    else if (take && op == crs_pkg::OP_LOAD_A)
      acc_q <= i_cmd.data;
    else if (take && op == crs_pkg::OP_ALU_A)
      acc_q <= alu_res;
    else if (take && op == crs_pkg::OP_MUL)
      acc_q <= product[7:0];
    else if (take && op == crs_pkg::OP_DIV && !div_err)
      acc_q <= quotient;
  end

  // ==========================================================
  // condition flags
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      flags_q <= crs_pkg::FLAGS_RESET;
    else if (state_q == crs_pkg::ST_PULL_D && cnt_q == crs_pkg::IDX_CCR)
      flags_q <= i_mem_rdata | crs_pkg::FLAGS_FIXED;
    else if (push_done && is_int_q)
      flags_q <= flags_q | (8'h01 << crs_pkg::FLAG_I);
    else if (take && op == crs_pkg::OP_LOAD_FLAGS)
      flags_q <= i_cmd.data | crs_pkg::FLAGS_FIXED;
    else if (take && (op == crs_pkg::OP_ALU_A || op == crs_pkg::OP_ALU_X))
    begin
      flags_q <= nz_flags(flags_q, alu_res);
      flags_q[crs_pkg::FLAG_C] <= alu_c;
      flags_q[crs_pkg::FLAG_V] <= alu_v;
    end
    else if (take && (op == crs_pkg::OP_LOAD_A || op == crs_pkg::OP_LOAD_X))
    begin
      flags_q <= nz_flags(flags_q, i_cmd.data);
      flags_q[crs_pkg::FLAG_V] <= 1'b0;
    end
    else if (take && op == crs_pkg::OP_MUL)
    begin
      flags_q[crs_pkg::FLAG_C] <= 1'b0;
      flags_q[crs_pkg::FLAG_H] <= 1'b0;
    end
    else if (take && op == crs_pkg::OP_DIV)
    begin
      flags_q[crs_pkg::FLAG_C] <= div_err;
      flags_q[crs_pkg::FLAG_Z] <= !div_err && (quotient == crs_pkg::ZERO8);
    end
  end

  // ==========================================================
  // outputs
  // visible only as ports
  assign o_busy = (state_q != crs_pkg::ST_IDLE);
  assign o_regs.acc = acc_q;
  assign o_regs.index_pair = {h_q, x_q};
  assign o_regs.stack_pointer = sp_q;
  assign o_regs.program_counter = pc_q;
  assign o_regs.condition_flags = flags_q | crs_pkg::FLAGS_FIXED;

endmodule

`default_nettype wire

// >>> tb_top.sv
/*
  self-checking testbench for crs_register_set with random operands.
  assumes crs_mem_model on the memory port and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_cmd_valid = 1'b0;
  crs_pkg::crs_cmd_type i_cmd = '0;
  crs_pkg::crs_fn_type fn = crs_pkg::FN_CLR;
  logic tk = 1'b0;
  logic [7:0] rdata;
  logic o_busy;
  crs_pkg::crs_mem_type o_mem;
  crs_pkg::crs_regs_type r;
  int errors = 0;
  int compares = 0;
  logic [15:0] pc, sp, hx, v, da;
  logic [7:0] a, d;
  logic c;

  always #20 i_clock = ~i_clock;

  crs_register_set DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_mem_rdata(rdata), .o_busy(o_busy), .o_mem(o_mem), .o_direct_addr(da),
    .o_regs(r));
  crs_mem_model MEM (.i_clock(i_clock), .i_mem(o_mem), .o_rdata(rdata));

  // ==========================================================
  // expectation functions
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  function automatic logic [7:0] fx(input logic [3:0] f, input logic [7:0] b, input logic ci);
    case (f)
      4'h0: return 8'h00;
      4'h1: return b + 8'h01;
      4'h2: return b - 8'h01;
      4'h3: return ~b;
      4'h4: return 8'h00 - b;
      4'h5: return {b[6:0], 1'b0};
      4'h6: return {1'b0, b[7:1]};
      4'h7: return {b[7], b[7:1]};
      4'h8: return {b[6:0], ci};
      default: return {ci, b[7:1]};
    endcase
  endfunction

  // ==========================================================
  // tasks
  task automatic finish_test;
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    chk16({8'h00, g}, {8'h00, e});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (o_busy !== 1'b0)
    begin
      @(negedge i_clock);
      n++;
      if (n > 50)
      begin
        errors++;
        finish_test();
      end
    end
  endtask

  task automatic send(input crs_pkg::crs_op_type op, input logic [7:0] dt,
    input logic [15:0] tg);
    wait_idle();
    i_cmd = '{op, fn, dt, tg, tk};
    i_cmd_valid = 1'b1;
    @(negedge i_clock);
    i_cmd_valid = 1'b0;
    @(negedge i_clock);
    wait_idle();
  endtask

  task automatic do_reset;
    i_reset_n = 1'b0;
    repeat (5) @(negedge i_clock);
    i_reset_n = 1'b1;
    @(negedge i_clock);
    wait_idle();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    v = 16'($urandom(55));
    MEM.mem[16'hfffe] = 8'h12;
    MEM.mem[16'hffff] = 8'h34;
    do_reset();
    chk16(r.program_counter, 16'h1234);
    chk8(r.condition_flags & 8'h60, 8'h60);
    a = 8'($urandom);
    hx = 16'($urandom);
    send(crs_pkg::OP_LOAD_A, a, '0);
    send(crs_pkg::OP_LOAD_HX, 8'h00, hx);
    do_reset();
    chk8(r.acc, a);
    chk16(r.index_pair, {8'h00, hx[7:0]});
    chk16(r.stack_pointer, 16'h00ff);
    pc = 16'h1234;
    sp = 16'h00ff;
    for (int i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 8'h80 : 8'($urandom);
      tk = ~i[0];
      send(crs_pkg::OP_BRANCH, d, '0);
      pc = pc + (tk ? sx(d) : 16'h0000);
      chk16(r.program_counter, pc);
      send(crs_pkg::OP_ADD_IMMEDIATE_TO_STACK, ~d, '0);
      sp = sp + sx(~d);
      chk16(r.stack_pointer, sp);
      send(crs_pkg::OP_FETCH, 8'h00, '0);
      pc = pc + 16'h0001;
      chk16(r.program_counter, pc);
    end
    v = 16'($urandom);
    send(crs_pkg::OP_LOAD_SP, 8'h00, v);
    send(crs_pkg::OP_STACK_LOW_BYTE_RESET, 8'h00, '0);
    chk16(r.stack_pointer, {v[15:8], 8'hff});
    send(crs_pkg::OP_JUMP, 8'h00, v);
    pc = v;
    chk16(r.program_counter, pc);
    send(crs_pkg::OP_LOAD_SP, 8'h00, 16'h0200);
    v = 16'($urandom);
    send(crs_pkg::OP_CALL, 8'h00, v);
    chk16(r.program_counter, v);
    chk16({MEM.mem[16'h01ff], MEM.mem[16'h0200]}, pc);
    chk16(r.stack_pointer, 16'h01fe);
    send(crs_pkg::OP_RETURN, 8'h00, '0);
    chk16(r.program_counter, pc);
    MEM.mem[16'hfff8] = 8'h56;
    MEM.mem[16'hfff9] = 8'h78;
    send(crs_pkg::OP_LOAD_FLAGS, 8'h00, '0);
    send(crs_pkg::OP_INTERRUPT, 8'h00, 16'hfff8);
    chk16(r.program_counter, 16'h5678);
    chk8(MEM.mem[16'h01fc], 8'h60);
    chk8(r.condition_flags & 8'h08, 8'h08);
    send(crs_pkg::OP_RETURN_INT, 8'h00, '0);
    chk16(r.program_counter, pc);
    chk16(r.stack_pointer, 16'h0200);
    for (int i = 0; i < 10; i++)
    begin
      c = 1'($urandom);
      d = 8'($urandom);
      send(crs_pkg::OP_LOAD_FLAGS, {7'h00, c}, '0);
      send(crs_pkg::OP_LOAD_X, d, '0);
      fn = crs_pkg::crs_fn_type'(i);
      send(crs_pkg::OP_ALU_X, 8'h00, '0);
      fn = crs_pkg::FN_CLR;
      chk8(r.index_pair[7:0], fx(i[3:0], d, c));
    end
    send(crs_pkg::OP_LOAD_HX, 8'h00, 16'h12ff);
    send(crs_pkg::OP_HX_POST_INC, 8'h00, '0);
    chk16(r.index_pair, 16'h1300);
    a = 8'($urandom);
    d = 8'($urandom) | 8'h01;
    send(crs_pkg::OP_LOAD_A, a, '0);
    send(crs_pkg::OP_LOAD_X, d, '0);
    send(crs_pkg::OP_MUL, 8'h00, '0);
    chk16({r.index_pair[7:0], r.acc}, 16'(a) * 16'(d));
    send(crs_pkg::OP_LOAD_H, 8'h00, '0);
    send(crs_pkg::OP_LOAD_X, d, '0);
    send(crs_pkg::OP_LOAD_A, a, '0);
    send(crs_pkg::OP_DIV, 8'h00, '0);
    chk16({r.index_pair[15:8], r.acc}, {a % d, a / d});
    fn = crs_pkg::FN_COM;
    send(crs_pkg::OP_ALU_A, 8'h00, '0);
    chk8(r.acc, ~(a / d));
    d = 8'($urandom);
    MEM.mem[16'h4321] = d;
    send(crs_pkg::OP_MOVE, 8'h40, 16'h4321);
    chk8(MEM.mem[16'h0040], d);
    chk16(da, 16'h0040);
    finish_test();
  end
endmodule

`default_nettype wire
